// ---- common/picdr_pkg.sv ----
// Purpose: shared constants and carrier types for the interrupt, cable-test and control registers
// Assumes: 16-bit management registers addressed by a 5-bit register number
// Notes: offsets are management register numbers, not byte addresses
`default_nettype none
package picdr_pkg;
  // register numbers
  localparam logic [4:0] REG_INT_CS = 5'h1b;
  localparam logic [4:0] REG_DIAG_CS = 5'h1d;
  localparam logic [4:0] REG_PHY_CTL1 = 5'h1e;
  localparam logic [4:0] REG_PHY_CTL2 = 5'h1f;
  localparam int REG_W = 16;
  localparam int ADDR_W = 5;
  // interrupt control/status layout
  localparam int FLAG_W = 8;
  localparam int INT_EN_LSB = 8;
  localparam int LINK_UP_EN_BIT = 8;
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  // cable diagnostic layout
  localparam int DIAG_START_BIT = 15;
  localparam int DIAG_RES_LSB = 13;
  localparam int DIAG_RSV_W = 4;
  localparam int DIAG_CNT_W = 9;
  localparam logic [1:0] DIAG_RES_RST = 2'h0;
  localparam logic [8:0] DIAG_CNT_RST = 9'h000;
  localparam logic [1:0] DIAG_RES_NORMAL = 2'h0;
  localparam logic [1:0] DIAG_RES_OPEN = 2'h1;
  localparam logic [1:0] DIAG_RES_SHORT = 2'h2;
  localparam logic [1:0] DIAG_RES_FAILED = 2'h3;
  // control register 1 layout
  localparam int LED_MODE_LSB = 14;
  localparam int POLARITY_BIT = 13;
  localparam int FAR_FAULT_BIT = 12;
  localparam int MDIX_BIT = 11;
  localparam int CTL1_LOW_W = 11;
  localparam logic [1:0] LED_MODE_RST = 2'h0;
  localparam logic [1:0] LED_MODE_SPEED = 2'h0;
  localparam logic [1:0] LED_MODE_ACT = 2'h1;
  // control register 2: only the interrupt level bit lives here
  localparam int IRQ_POL_BIT = 9;
  localparam logic IRQ_POL_RST = 1'b0;
  // management frame
  localparam logic [5:0] MDIO_PRE_LEN = 6'h20;
  localparam logic [5:0] MDIO_HDR_LEN = 6'h0e;
  localparam logic [5:0] MDIO_TA_LEN = 6'h02;
  localparam logic [5:0] MDIO_DATA_LEN = 6'h10;
  localparam logic [1:0] MDIO_ST = 2'h1;
  localparam logic [1:0] MDIO_OP_RD = 2'h2;
  localparam logic [1:0] MDIO_OP_WR = 2'h1;
  // event pulses, packed in flag bit order 7..0
  typedef struct packed {
    logic jabber;
    logic rx_error;
    logic page_rx;
    logic pd_fault;
    logic lp_ack;
    logic link_down;
    logic remote_fault;
    logic link_up;
  } picdr_event_t;
  // one register access from the management engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } picdr_req_t;
  // cable test outcome
  typedef struct packed {
    logic [1:0] result;
    logic [8:0] count;
  } picdr_diag_res_t;
endpackage
`default_nettype wire

// ---- hdl/picdr_mdio_engine.sv ----
// Purpose: serial management frame engine turning frames into register accesses
// Assumes: mdc_in sampled on the core clock, at most a sixth of its rate
// Notes: drives read data after each mdc rising edge; ignores frames for other addresses
`timescale 1ns/1ps
`default_nettype none
module picdr_mdio_engine #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // management pins
  input wire logic mdc_in,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_out,
  // register side
  output picdr_pkg::picdr_req_t req_out,
  input wire logic [15:0] rdata_in
);
  typedef enum logic [3:0] {
    S_PRE = 4'b0001,
    S_HDR = 4'b0010,
    S_TA = 4'b0100,
    S_DATA = 4'b1000
  } picdr_mdio_st_t;

  picdr_mdio_st_t state_reg;
  logic mdc_prev_reg;
  logic [5:0] cnt_reg;
  logic [15:0] shift_reg;
  logic is_rd_reg;
  logic mdio_out_reg;
  logic mdio_oe_reg;
  picdr_pkg::picdr_req_t req_reg;

  // header decode on the last header bit
  wire mdc_rise = mdc_in & ~mdc_prev_reg;
  wire [13:0] hdr_w = {shift_reg[12:0], mdio_in};
  wire op_rd_w = hdr_w[11:10] == picdr_pkg::MDIO_OP_RD;
  wire op_wr_w = hdr_w[11:10] == picdr_pkg::MDIO_OP_WR;
  wire hit_w = (hdr_w[13:12] == picdr_pkg::MDIO_ST) && (hdr_w[9:5] == PHY_ADDR) &&
               (op_rd_w || op_wr_w);
  wire [5:0] cnt_inc = cnt_reg + 6'h01;

  assign mdio_out = mdio_out_reg;
  assign mdio_oe_out = mdio_oe_reg;
  assign req_out = req_reg;

  // frame sequencer; one step per mdc rising edge
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= S_PRE;
      mdc_prev_reg <= 1'b0;
      cnt_reg <= 6'h00;
      shift_reg <= 16'h0000;
      is_rd_reg <= 1'b0;
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
      req_reg <= '0;
    end else begin
      mdc_prev_reg <= mdc_in;
      req_reg.rd <= 1'b0;
      req_reg.wr <= 1'b0;
      // read data arrives the cycle after the read strobe
      if (req_reg.rd) begin
        shift_reg <= rdata_in;
      end
      if (mdc_rise) begin
        unique case (state_reg)
          S_PRE: begin
            if (mdio_in) begin
              cnt_reg <= (cnt_reg == picdr_pkg::MDIO_PRE_LEN) ? cnt_reg : cnt_inc;
            end else if (cnt_reg == picdr_pkg::MDIO_PRE_LEN) begin
              state_reg <= S_HDR;
              shift_reg <= 16'h0000;
              cnt_reg <= 6'h01;
            end else begin
              cnt_reg <= 6'h00;
            end
          end
          S_HDR: begin
            shift_reg <= {shift_reg[14:0], mdio_in};
            cnt_reg <= cnt_inc;
            if (cnt_inc == picdr_pkg::MDIO_HDR_LEN) begin
              cnt_reg <= 6'h00;
              state_reg <= hit_w ? S_TA : S_PRE;
              is_rd_reg <= op_rd_w;
              req_reg.addr <= hdr_w[4:0];
              req_reg.rd <= hit_w & op_rd_w;
            end
          end
          S_TA: begin
            cnt_reg <= cnt_inc;
            // a read drives the second turnaround bit low
            if (is_rd_reg) begin
              mdio_oe_reg <= 1'b1;
              mdio_out_reg <= 1'b0;
              cnt_reg <= 6'h00;
              state_reg <= S_DATA;
            end else if (cnt_inc == picdr_pkg::MDIO_TA_LEN) begin
              cnt_reg <= 6'h00;
              state_reg <= S_DATA;
            end
          end
          S_DATA: begin
            cnt_reg <= cnt_inc;
            if (is_rd_reg) begin
              if (cnt_reg == picdr_pkg::MDIO_DATA_LEN) begin
                mdio_oe_reg <= 1'b0;
                cnt_reg <= 6'h00;
                state_reg <= S_PRE;
              end else begin
                mdio_out_reg <= shift_reg[15];
                shift_reg <= {shift_reg[14:0], 1'b0};
              end
            end else begin
              shift_reg <= {shift_reg[14:0], mdio_in};
              if (cnt_inc == picdr_pkg::MDIO_DATA_LEN) begin
                req_reg.wdata <= {shift_reg[14:0], mdio_in};
                req_reg.wr <= 1'b1;
                cnt_reg <= 6'h00;
                state_reg <= S_PRE;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/picdr_regs.sv ----
// Purpose: interrupt control/status, cable test control/status and indicator control registers
// Assumes: event and status inputs synchronous to CLK_IN; event inputs are one-cycle pulses
// Notes: reached only through the serial management pins; unmapped registers read zero
// Behaviour
// (R1) bit 8 of interrupt register enables link-up interrupt, resets 0
// (R2) bit 7 latches jabber, clears on read, resets 0
// (R3) bit 6 latches receive error, clears on read, resets 0
// (R4) bit 5 latches page received, clears on read, resets 0
// (R5) bit 4 latches parallel detect fault, clears on read, resets 0
// (R6) bit 3 latches partner acknowledge, clears on read, resets 0
// (R7) bit 2 latches link down, clears on read, resets 0
// (R8) bit 1 latches remote fault, clears on read, resets 0
// (R9) bit 0 latches link up, clears on read, resets 0
// (R10) writing 1 to cable bit 15 starts test; hardware clears it when done
// (R11) cable bit 15 at zero means results valid; manager reads after that
// (R12) result field 14:13: normal, open, short, failed; resets 00
// (R13) bits 8:0 hold fault distance count, about 0.4 m each, reset zero
// (R14) indicator mode 15:14: 00 speed and link/activity, 01 activity and link
// (R15) control bit 13 reads reversed receive polarity
// (R16) control bit 12 reads far-end fault, fiber variant only
// (R17) interrupt bits 15:9 enable the other seven events, reset 0
// (R18) control bit selects interrupt pin level, 1 high, 0 low, reset 0
// (R19) interrupt asserted while any enabled flag set, released once all read
// (R20) control bit 11 reads 0 for straight mode, 1 for crossover mode
`timescale 1ns/1ps
`default_nettype none
module picdr_regs #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic ARST_N_IN,
  // management pins
  input wire logic MDC_IN,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_OUT,
  // event pulses from the core
  input wire picdr_pkg::picdr_event_t EVENT_IN,
  // line status from the core
  input wire logic LINK_UP_IN,
  input wire logic SPEED_100_IN,
  input wire logic ACTIVITY_IN,
  input wire logic POLARITY_REV_IN,
  input wire logic FAR_END_FAULT_IN,
  input wire logic MDIX_STATE_IN,
  // cable test engine
  output logic DIAG_START_OUT,
  input wire logic DIAG_DONE_IN,
  input wire picdr_pkg::picdr_diag_res_t DIAG_RESULT_IN,
  // interrupt and indicators
  output logic INT_OUT,
  output logic FIRST_INDICATOR_OUT,
  output logic SECOND_INDICATOR_OUT
);
  picdr_pkg::picdr_req_t req;
  logic [15:0] rdata;
  logic [7:0] int_en_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic irq_pol_reg;
  logic int_reg;
  logic diag_busy_reg;
  logic diag_start_reg;
  logic [1:0] diag_res_reg;
  logic [8:0] diag_cnt_reg;
  logic [1:0] led_mode_reg;
  logic first_led_reg;
  logic second_led_reg;

  // serial frame engine
  picdr_mdio_engine #(
    .PHY_ADDR(PHY_ADDR)
  ) u_mdio (
    .clk_in(CLK_IN),
    .arst_n_in(ARST_N_IN),
    .mdc_in(MDC_IN),
    .mdio_in(MDIO_IN),
    .mdio_out(MDIO_OUT),
    .mdio_oe_out(MDIO_OE_OUT),
    .req_out(req),
    .rdata_in(rdata)
  );

  // address decode
  wire sel_int = req.addr == picdr_pkg::REG_INT_CS;
  wire sel_diag = req.addr == picdr_pkg::REG_DIAG_CS;
  wire sel_ctl1 = req.addr == picdr_pkg::REG_PHY_CTL1;
  wire sel_ctl2 = req.addr == picdr_pkg::REG_PHY_CTL2;
  wire rd_int = req.rd & sel_int;
  wire wr_int = req.wr & sel_int;
  wire wr_diag = req.wr & sel_diag;
  wire wr_ctl1 = req.wr & sel_ctl1;
  wire wr_ctl2 = req.wr & sel_ctl2;
  // a start while a test runs is dropped; the test cannot be aborted
  wire diag_go = wr_diag & req.wdata[picdr_pkg::DIAG_START_BIT] & ~diag_busy_reg;
  wire diag_end = DIAG_DONE_IN & diag_busy_reg;

  // read values; status bits are sampled live at the read strobe
  wire [15:0] int_val = {int_en_reg, flag_reg};
  wire [15:0] diag_val = {diag_busy_reg, diag_res_reg, {picdr_pkg::DIAG_RSV_W{1'b0}},
                          diag_cnt_reg}; // R11 R12 R13
  wire [15:0] ctl1_val = {led_mode_reg, POLARITY_REV_IN, FAR_END_FAULT_IN, MDIX_STATE_IN,
                          {picdr_pkg::CTL1_LOW_W{1'b0}}}; // R15 R16 R20
  wire [15:0] ctl2_val = 16'(irq_pol_reg) << picdr_pkg::IRQ_POL_BIT;
  assign rdata = sel_int ? int_val :
                 sel_diag ? diag_val :
                 sel_ctl1 ? ctl1_val :
                 sel_ctl2 ? ctl2_val : 16'h0000;

  // flags: a new event beats the clear-on-read of the same cycle
  assign flag_next = (flag_reg & ~{picdr_pkg::FLAG_W{rd_int}}) | EVENT_IN; // R2 R3 R4 R5 R6 R7 R8 R9

  // enabled flags pending; enable bit i+8 pairs with flag bit i
  wire irq_pend = |(flag_reg & int_en_reg); // R19
  wire int_next = irq_pol_reg ? irq_pend : ~irq_pend; // R18

  // interrupt enables and status flags
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      int_en_reg <= picdr_pkg::INT_EN_RST;
      flag_reg <= picdr_pkg::FLAG_RST;
    end else begin
      if (wr_int) begin
        int_en_reg <= req.wdata[picdr_pkg::INT_EN_LSB +: picdr_pkg::FLAG_W]; // R1 R17
      end
      flag_reg <= flag_next;
    end
  end

  // interrupt pin level and polarity; reset idles at the active-low release level
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_pol_reg <= picdr_pkg::IRQ_POL_RST;
      int_reg <= 1'b1;
    end else begin
      if (wr_ctl2) begin
        irq_pol_reg <= req.wdata[picdr_pkg::IRQ_POL_BIT]; // R18
      end
      int_reg <= int_next; // R19
    end
  end
  assign INT_OUT = int_reg;

  // cable test handshake: busy bit is the self-clearing start bit
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      diag_busy_reg <= 1'b0;
      diag_start_reg <= 1'b0;
      diag_res_reg <= picdr_pkg::DIAG_RES_RST;
      diag_cnt_reg <= picdr_pkg::DIAG_CNT_RST;
    end else begin
      diag_start_reg <= diag_go; // R10
      if (diag_go) begin
        diag_busy_reg <= 1'b1; // R10
      end else if (diag_end) begin
        diag_busy_reg <= 1'b0; // R10 R11
        diag_res_reg <= DIAG_RESULT_IN.result; // R12
        diag_cnt_reg <= DIAG_RESULT_IN.count; // R13
      end
    end
  end
  assign DIAG_START_OUT = diag_start_reg;

  // indicator selection; reserved modes leave both indicators dark
  wire mode_speed = led_mode_reg == picdr_pkg::LED_MODE_SPEED;
  wire mode_act = led_mode_reg == picdr_pkg::LED_MODE_ACT;
  wire link_act = LINK_UP_IN & ~ACTIVITY_IN; // lit on link, blinks off with traffic
  wire first_next = mode_speed ? link_act : (mode_act & LINK_UP_IN); // R14
  wire second_next = mode_speed ? SPEED_100_IN : (mode_act & ACTIVITY_IN); // R14

  // indicator mode and registered indicator outputs
  always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      led_mode_reg <= picdr_pkg::LED_MODE_RST;
      first_led_reg <= 1'b0;
      second_led_reg <= 1'b0;
    end else begin
      if (wr_ctl1) begin
        led_mode_reg <= req.wdata[picdr_pkg::LED_MODE_LSB +: 2]; // R14
      end
      first_led_reg <= first_next;
      second_led_reg <= second_next;
    end
  end
  assign FIRST_INDICATOR_OUT = first_led_reg;
  assign SECOND_INDICATOR_OUT = second_led_reg;

  // checks on the register behaviour
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!ARST_N_IN);

  property p_link_up_en;
    wr_int |=> int_en_reg[0] == $past(req.wdata[picdr_pkg::LINK_UP_EN_BIT]);
  endproperty
  a_link_up_en: assert property (p_link_up_en) // R1
    else $error("link-up enable did not take the written value");

  property p_jabber_set;
    EVENT_IN.jabber |=> flag_reg[7] ##1 (flag_reg[7] || $past(rd_int));
  endproperty
  a_jabber_set: assert property (p_jabber_set) // R2
    else $error("jabber flag not held after event");

  property p_rx_err_clear;
    rd_int && !EVENT_IN.rx_error |=> !flag_reg[6];
  endproperty
  a_rx_err_clear: assert property (p_rx_err_clear) // R3
    else $error("receive error flag survived a read");

  property p_page_hold;
    flag_reg[5] && !rd_int |=> flag_reg[5];
  endproperty
  a_page_hold: assert property (p_page_hold) // R4
    else $error("page received flag dropped without a read");

  property p_flag_cause;
    (flag_reg & ~$past(flag_reg) & ~$past(EVENT_IN)) == 8'h00;
  endproperty
  a_flag_cause: assert property (p_flag_cause) // R9
    else $error("status flag rose without an event");

  property p_enables_write;
    wr_int |=> int_en_reg[7:1] == $past(req.wdata[15:9]);
  endproperty
  a_enables_write: assert property (p_enables_write) // R17
    else $error("event enables did not take the written value");

  property p_diag_start;
    diag_go |=> diag_busy_reg && DIAG_START_OUT ##1 !DIAG_START_OUT;
  endproperty
  a_diag_start: assert property (p_diag_start) // R10
    else $error("cable test start not seen as busy and one pulse");

  property p_diag_done;
    diag_end |=> !diag_busy_reg && diag_res_reg == $past(DIAG_RESULT_IN.result) &&
                 diag_cnt_reg == $past(DIAG_RESULT_IN.count);
  endproperty
  a_diag_done: assert property (p_diag_done) // R11
    else $error("results not captured when the test ended");

  property p_diag_res_stable;
    diag_busy_reg || !$past(diag_busy_reg) |-> $stable(diag_res_reg);
  endproperty
  a_diag_res_stable: assert property (p_diag_res_stable) // R12
    else $error("result field changed outside test completion");

  property p_led_act_mode;
    mode_act |=> FIRST_INDICATOR_OUT == $past(LINK_UP_IN) &&
                 SECOND_INDICATOR_OUT == $past(ACTIVITY_IN);
  endproperty
  a_led_act_mode: assert property (p_led_act_mode) // R14
    else $error("indicators wrong in activity mode");

  property p_polarity_read;
    req.rd && sel_ctl1 |-> rdata[picdr_pkg::POLARITY_BIT] == POLARITY_REV_IN &&
                          rdata[picdr_pkg::MDIX_BIT] == MDIX_STATE_IN;
  endproperty
  a_polarity_read: assert property (p_polarity_read) // R15
    else $error("control status bits not returned on read");

  property p_int_level;
    ##1 INT_OUT == ($past(irq_pol_reg) ~^ $past(irq_pend));
  endproperty
  a_int_level: assert property (p_int_level) // R18
    else $error("interrupt pin level disagrees with pending and polarity");

  property p_int_release;
    rd_int && EVENT_IN == 8'h00 && irq_pol_reg |=> ##1 !INT_OUT;
  endproperty
  a_int_release: assert property (p_int_release) // R19
    else $error("interrupt still asserted after flags were read");

  // main scenarios
  c_flag_read: cover property (flag_reg != 8'h00 ##[1:20] rd_int);
  c_diag_cycle: cover property (diag_go ##[1:50] diag_end);
  c_set_and_clear: cover property (rd_int && EVENT_IN != 8'h00);
  c_int_high: cover property (irq_pol_reg && INT_OUT);
endmodule
`default_nettype wire

// ---- verif/picdr_mgmt_model.sv ----
// Purpose: station manager model driving serial management frames into the register block
// Assumes: management clock is a slow divide of the core clock, eight core cycles a bit
// Notes: the shared data line has a pull-up, so a released line reads one
`timescale 1ns/1ps
`default_nettype none
module picdr_mgmt_model (
  // clock
  input wire logic clk_in,
  // device side of the shared data line
  input wire logic dev_data_in,
  input wire logic dev_oe_in,
  // management pins toward the device
  output logic mdc_out,
  output logic mdio_out,
  // read results toward the bench
  output logic rd_valid_out,
  output logic [15:0] rd_data_out
);
  logic drv_en;
  logic drv_val;
  logic line;
  // wire level from both drivers, pull-up when nobody drives
  assign line = dev_oe_in ? dev_data_in : (drv_en ? drv_val : 1'b1);
  assign mdio_out = line;
  // the clock stands low and the line is released outside frames
  initial begin
    mdc_out = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
    rd_valid_out = 1'b0;
    rd_data_out = 16'h0000;
  end
  // one bit: data set while the clock is low, line sampled just before the rise
  task automatic put_bit(input logic b, input logic drv, output logic smp);
    @(negedge clk_in);
    mdc_out = 1'b0;
    drv_en = drv;
    drv_val = b;
    repeat (3) @(negedge clk_in);
    smp = line;
    mdc_out = 1'b1;
    repeat (4) @(negedge clk_in);
  endtask
  // whole frame with its own full preamble; the line is released for read turnaround
  task automatic xfer(input logic rd, input logic [4:0] phy, input logic [4:0] regad,
                      input logic [15:0] wdata);
    logic [63:0] bits;
    logic s;
    logic [15:0] got;
    bits = {32'hffffffff, picdr_pkg::MDIO_ST, rd ? picdr_pkg::MDIO_OP_RD : picdr_pkg::MDIO_OP_WR,
            phy, regad, 2'h2, wdata};
    got = 16'h0000;
    for (int i = 63; i >= 0; i--) begin
      put_bit(bits[i], !rd || i > 17, s);
      if (i < 16) begin
        got[i] = s;
      end
    end
    @(negedge clk_in);
    mdc_out = 1'b0;
    drv_en = 1'b0;
    if (rd) begin
      rd_data_out = got;
      rd_valid_out = 1'b1;
      @(negedge clk_in);
      rd_valid_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_picdr_regs.sv ----
// Purpose: self-checking bench for the interrupt, cable test and control registers
// Assumes: device address 1; inputs change on the falling clock edge
// Notes: expected read values are queued by the driver and compared when the manager returns the reads
`timescale 1ns/1ps
`default_nettype none
module tb_picdr_regs;
  logic clk, arst_n, mdc, mdio_wire, dev_mdio, dev_oe;
  logic link, spd, act, pol, far, mdix, diag_start, diag_done, irq, ind0, ind1, rd_valid;
  logic [15:0] rd_data;
  picdr_pkg::picdr_event_t ev;
  picdr_pkg::picdr_diag_res_t dres;
  logic [15:0] exp_q[$];
  int mismatches, checked, cycles, starts;
  integer seed = 32'h0e1d;

  picdr_regs #(.PHY_ADDR(5'h01)) dut (.CLK_IN(clk), .ARST_N_IN(arst_n), .MDC_IN(mdc),
    .MDIO_IN(mdio_wire), .MDIO_OUT(dev_mdio), .MDIO_OE_OUT(dev_oe), .EVENT_IN(ev),
    .LINK_UP_IN(link), .SPEED_100_IN(spd), .ACTIVITY_IN(act), .POLARITY_REV_IN(pol),
    .FAR_END_FAULT_IN(far), .MDIX_STATE_IN(mdix), .DIAG_START_OUT(diag_start),
    .DIAG_DONE_IN(diag_done), .DIAG_RESULT_IN(dres), .INT_OUT(irq),
    .FIRST_INDICATOR_OUT(ind0), .SECOND_INDICATOR_OUT(ind1));
  picdr_mgmt_model mgr (.clk_in(clk), .dev_data_in(dev_mdio), .dev_oe_in(dev_oe),
    .mdc_out(mdc), .mdio_out(mdio_wire), .rd_valid_out(rd_valid), .rd_data_out(rd_data));

  // 25 MHz core clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic pin(input logic got, input logic exp);
    check({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    mgr.xfer(1'b1, 5'h01, a, 16'h0000);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgr.xfer(1'b0, 5'h01, a, d);
  endtask
  // one-cycle event pulse, then time for the pin to follow
  task automatic pulse(input logic [7:0] e);
    @(negedge clk);
    ev = e;
    @(negedge clk);
    ev = 8'h00;
    repeat (3) @(negedge clk);
  endtask
  task automatic done_pulse(input picdr_pkg::picdr_diag_res_t r);
    @(negedge clk);
    dres = r;
    diag_done = 1'b1;
    @(negedge clk);
    diag_done = 1'b0;
    dres = ~r;
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watcher: oldest note against each returned read, start pulses, hang limit
  always @(posedge clk) begin
    cycles++;
    if (diag_start === 1'b1) begin
      starts++;
    end
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        mismatches++;
        $display("BAD t=%0t got=%h exp=none", $time, rd_data);
      end else begin
        check(rd_data, exp_q.pop_front());
      end
    end
    if (cycles == 60000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    logic [7:0] en, evd, evs;
    logic lvl, e0, e1;
    logic [8:0] cnt;
    logic [5:0] st;
    int s0;
    arst_n = 1'b0;
    ev = 8'h00;
    {link, spd, act, pol, far, mdix, diag_done} = 7'h00;
    dres = 11'h000;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    rd(picdr_pkg::REG_INT_CS, 16'h0000);
    rd(picdr_pkg::REG_DIAG_CS, 16'h0000);
    rd(picdr_pkg::REG_PHY_CTL1, 16'h0000);
    rd(picdr_pkg::REG_PHY_CTL2, 16'h0000);
    rd(5'h00, 16'h0000);
    pin(irq, 1'b1);
    // frames for another address: no drive, write dropped
    exp_q.push_back(16'hffff);
    mgr.xfer(1'b1, 5'h02, picdr_pkg::REG_INT_CS, 16'h0000);
    mgr.xfer(1'b0, 5'h02, picdr_pkg::REG_PHY_CTL2, 16'h0200);
    rd(picdr_pkg::REG_PHY_CTL2, 16'h0000);
    $display("test reset and addressing done");
    // each flag with only its own enable, both pin levels
    for (int i = 0; i < 8; i++) begin
      lvl = i[0];
      en = 8'h01 << i;
      wr(picdr_pkg::REG_PHY_CTL2, {6'h00, lvl, 9'h000});
      wr(picdr_pkg::REG_INT_CS, {en, 8'hff});
      evd = 8'($random(seed)) & ~en;
      pulse(evd);
      pin(irq, ~lvl);
      evs = 8'($random(seed)) | en;
      pulse(evs);
      pin(irq, lvl);
      rd(picdr_pkg::REG_INT_CS, {en, evd | evs});
      repeat (3) @(negedge clk);
      pin(irq, ~lvl);
      rd(picdr_pkg::REG_INT_CS, {en, 8'h00});
    end
    $display("test event flags done");
    // every result code; a second start while busy is ignored
    cnt = 9'h000;
    for (int c = 0; c < 4; c++) begin
      s0 = starts;
      wr(picdr_pkg::REG_DIAG_CS, 16'h8000);
      wr(picdr_pkg::REG_DIAG_CS, 16'h8000);
      check(16'(starts - s0), 16'h0001);
      // while busy the fields still show the previous test's outcome
      rd(picdr_pkg::REG_DIAG_CS, {1'b1, ((c == 0) ? 2'h0 : 2'(c - 1)), 4'h0, cnt});
      cnt = 9'($random(seed));
      done_pulse({c[1:0], cnt});
      rd(picdr_pkg::REG_DIAG_CS, {1'b0, c[1:0], 4'h0, cnt});
    end
    done_pulse({2'h0, 9'h000});
    rd(picdr_pkg::REG_DIAG_CS, {1'b0, 2'h3, 4'h0, cnt});
    $display("test cable diagnostic done");
    // indicator modes and live status bits; read-only bits ignore writes
    for (int m = 0; m < 8; m++) begin
      st = 6'($random(seed));
      @(negedge clk);
      {link, spd, act, pol, far, mdix} = st;
      wr(picdr_pkg::REG_PHY_CTL1, {m[1:0], 14'h3fff});
      e1 = (m[1:0] == 2'h0) ? spd : ((m[1:0] == 2'h1) ? act : 1'b0);
      e0 = (m[1:0] == 2'h0) ? (link & ~act) : ((m[1:0] == 2'h1) ? link : 1'b0);
      pin(ind1, e1);
      pin(ind0, e0);
      rd(picdr_pkg::REG_PHY_CTL1, {m[1:0], pol, far, mdix, 11'h000});
    end
    $display("test indicators and status done");
    if (exp_q.size() != 0) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, exp_q.size(), 0);
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
